// ---- src/atclp_pkg.sv ----
`default_nettype none

package atclp_pkg;

    // Sizes of the command catalogue and of one parameter list
    localparam int NCMD  = 4;
    localparam int NPAR  = 4;
    localparam int PW    = 16;
    localparam int NAMEW = 64;
    localparam int CIW   = $clog2(NCMD);
    localparam int PIW   = $clog2(NPAR);
    localparam int SW    = PIW + 1;
    localparam int AW    = $clog2(NCMD * NPAR);

    // Characters of the command line
    localparam logic [7:0] CH_A       = 8'h41;
    localparam logic [7:0] CH_T       = 8'h54;
    localparam logic [7:0] CH_SLASH   = 8'h2f;
    localparam logic [7:0] CH_EQ      = 8'h3d;
    localparam logic [7:0] CH_QMARK   = 8'h3f;
    localparam logic [7:0] CH_COMMA   = 8'h2c;
    localparam logic [7:0] CH_SPACE   = 8'h20;
    localparam logic [7:0] CH_ZERO    = 8'h30;
    localparam logic [7:0] CH_NINE    = 8'h39;
    localparam logic [7:0] CH_LOW_A   = 8'h61;
    localparam logic [7:0] CH_LOW_Z   = 8'h7a;
    localparam logic [7:0] CH_CASE    = 8'h20;
    localparam logic [7:0] CH_CTRLZ   = 8'h1a;
    localparam logic [7:0] CH_ESC     = 8'h1b;
    localparam logic [7:0] TERM_DFLT  = 8'h0d;
    localparam logic [7:0] DEC_BASE   = 8'h0a;

    // Extended error codes
    localparam logic [7:0] CME_SYNTAX = 8'h23;
    localparam logic [7:0] CME_RANGE  = 8'h15;
    localparam logic [7:0] CME_NOSUP  = 8'h04;

    typedef enum logic [1:0] {OP_NONE, OP_EQ, OP_TEST, OP_READ} atclp_op_e;
    typedef enum logic [2:0] {F_EXEC, F_SET, F_TEST, F_READ, F_XREAD} atclp_form_e;
    typedef enum logic [1:0] {R_OK, R_ERROR, R_CME} atclp_res_e;
    typedef enum {
        S_IDLE, S_PFX, S_NAME, S_OPEQ, S_PARAM, S_TAIL, S_DATA,
        S_CHECK, S_WRITE, S_REPORT, S_FINAL
    } atclp_state_e;

    typedef struct packed {
        logic [NAMEW-1:0]         name;
        logic                     bare_ok;
        logic                     eq_exec;
        logic                     has_read;
        logic                     xread;
        logic                     has_data;
        logic [2:0]               npar;
        logic [NPAR-1:0]          mand;
        logic [NPAR-1:0]          has_def;
        logic [NPAR-1:0][PW-1:0]  dflt;
        logic [NPAR-1:0][PW-1:0]  lo;
        logic [NPAR-1:0][PW-1:0]  hi;
    } atclp_desc_s;

    typedef struct packed {
        logic [NAMEW-1:0]         name;
        atclp_op_e                op;
        logic [NPAR-1:0][PW-1:0]  val;
        logic [NPAR-1:0]          pres;
        logic                     xtra;
        logic                     syn;
    } atclp_line_s;

    typedef struct packed {
        logic                     valid;
        atclp_res_e               code;
        logic [7:0]               cme;
    } atclp_res_s;

    typedef struct packed {
        logic                     valid;
        logic [CIW-1:0]           cmd;
        atclp_form_e              form;
        logic [NPAR-1:0]          given;
        logic [NPAR-1:0][PW-1:0]  val;
    } atclp_act_s;

    typedef struct packed {
        logic                     valid;
        logic                     is_range;
        logic [PIW-1:0]           idx;
        logic                     defined;
        logic [PW-1:0]            val;
        logic [PW-1:0]            hi;
    } atclp_rpt_s;

    // Catalogue: basic A, +CMD2 (execution read), +CMD3 (set), +CMD7 (execution with user data)
    localparam atclp_desc_s CMD_TABLE [NCMD] = '{
        '{name: 64'h41, bare_ok: 1'b1, eq_exec: 1'b0, has_read: 1'b0, xread: 1'b0,
          has_data: 1'b0, npar: 3'h0, mand: 4'h0, has_def: 4'h0,
          dflt: '0, lo: '0, hi: '0},
        '{name: 64'h2b_434d_4432, bare_ok: 1'b1, eq_exec: 1'b0, has_read: 1'b0, xread: 1'b1,
          has_data: 1'b0, npar: 3'h0, mand: 4'h0, has_def: 4'h0,
          dflt: '0, lo: '0, hi: '0},
        '{name: 64'h2b_434d_4433, bare_ok: 1'b0, eq_exec: 1'b0, has_read: 1'b1, xread: 1'b0,
          has_data: 1'b0, npar: 3'h4, mand: 4'h0, has_def: 4'h1,
          dflt: '0, lo: '0, hi: {16'hffff, 16'h000f, 16'h0001, 16'h0003}},
        '{name: 64'h2b_434d_4437, bare_ok: 1'b0, eq_exec: 1'b1, has_read: 1'b0, xread: 1'b0,
          has_data: 1'b1, npar: 3'h4, mand: 4'h4, has_def: 4'hb,
          dflt: {16'h0000, 16'h0000, 16'h0001, 16'h0003}, lo: '0,
          hi: {16'h00ff, 16'h0fff, 16'h0003, 16'h0003}}
    };

endpackage

`default_nettype wire

// ---- src/atclp_pmem.sv ----
`timescale 1ns/1ps
`default_nettype none

// Stored parameter values, one word per command and position
module atclp_pmem #(
    parameter int W     = 16,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // Clock
    input  wire logic          clk_i,
    // Write port
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic [W-1:0]  wr_data_i,
    // Read port, data one cycle later
    input  wire logic [AW-1:0] rd_addr_i,
    output logic      [W-1:0]  rd_data_o
);

    logic [W-1:0] mem_r [DEPTH];

    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem_r[rd_addr_i];
    end

endmodule // atclp_pmem

`default_nettype wire

// ---- src/atclp_parser.sv ----
// Behaviour
// RULE1: No operator means execution, action performed
// RULE2: Equals form execution or set per command
// RULE3: Set form stores values for later use
// RULE4: Test query reports ranges, then OK
// RULE5: Read query returns stored parameter values
// RULE6: Execution-read query fetches unit data instead
// RULE7: Commands storing nothing have no read form
// RULE8: Parameters taken positionally, comma separated
// RULE9: Empty position keeps later parameters aligned
// RULE10: Trailing optional parameters and commas droppable
// RULE11: Trailing drop judged per line separately
// RULE12: Host ignores unknown appended result parameters
// RULE13: Unknown appended parameters ignored or errored
// RULE14: New parameters sit before data line
// RULE15: Omitted parameter with default takes default
// RULE16: Else keep previous value, or undefined
// RULE17: Undefined needed parameter gives range error
// RULE18: Missing mandatory parameter gives syntax error
// RULE19: Line starts AT or at; A/ repeats
// RULE20: Plus sign marks an extended command
// RULE21: Terminator programmable, default carriage return
// RULE22: OK on success, ERROR on failure
// RULE23: Undefined forms rejected, stored values untouched
`timescale 1ns/1ps
`default_nettype none

module atclp_parser (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               nrst_i,
    // Character stream from the host side
    input  wire logic [7:0]         chr_i,
    input  wire logic               chr_valid_i,
    output logic                    chr_ready_o,
    // Configuration
    input  wire logic [7:0]         term_char_i,
    input  wire logic               xparm_err_i,
    input  wire logic               cme_mode_i,
    // Results towards the radio unit and host side
    output atclp_pkg::atclp_act_s   act_o,
    output atclp_pkg::atclp_rpt_s   rpt_o,
    output atclp_pkg::atclp_res_s   res_o
);

    atclp_pkg::atclp_state_e                          st_r, st_nxt;
    atclp_pkg::atclp_line_s                           line_r, line_nxt;
    atclp_pkg::atclp_line_s                           last_r;
    logic                                             prev_r;
    logic [atclp_pkg::PIW-1:0]                        pidx_r, pidx_nxt;
    logic [atclp_pkg::SW-1:0]                         step_r;
    logic [atclp_pkg::NCMD-1:0][atclp_pkg::NPAR-1:0]  vld_r;
    logic [atclp_pkg::NPAR-1:0][atclp_pkg::PW-1:0]    rval_r;
    atclp_pkg::atclp_res_s                            res_r, res_nxt;
    atclp_pkg::atclp_act_s                            act_r;
    atclp_pkg::atclp_rpt_s                            rpt_r, rpt_nxt;

    // Character classes
    wire logic       take    = chr_valid_i & chr_ready_o;
    wire logic       is_low  = (chr_i >= atclp_pkg::CH_LOW_A) && (chr_i <= atclp_pkg::CH_LOW_Z);
    wire logic [7:0] up_chr  = is_low ? (chr_i & ~atclp_pkg::CH_CASE) : chr_i;
    wire logic       is_term = (chr_i == term_char_i); // RULE21
    wire logic       is_sp   = (chr_i == atclp_pkg::CH_SPACE);
    wire logic       is_dig  = (chr_i >= atclp_pkg::CH_ZERO) && (chr_i <= atclp_pkg::CH_NINE);
    wire logic [atclp_pkg::PW-1:0] dig_val = atclp_pkg::PW'(chr_i - atclp_pkg::CH_ZERO);

    // Command lookup on the collected name; a leading plus is part of the name
    logic [atclp_pkg::NCMD-1:0] hit;
    logic [atclp_pkg::CIW-1:0]  cmd_w;
    generate
        for (genvar k = 0; k < atclp_pkg::NCMD; k++) begin : g_hit
            assign hit[k] = (line_r.name == atclp_pkg::CMD_TABLE[k].name); // RULE20
        end
    endgenerate

    always_comb begin
        cmd_w = '0;
        for (int k = 0; k < atclp_pkg::NCMD; k++) begin
            if (hit[k]) begin
                cmd_w = atclp_pkg::CIW'(k);
            end
        end
    end

    wire atclp_pkg::atclp_desc_s desc = atclp_pkg::CMD_TABLE[cmd_w];
    wire logic known = |hit;
    wire logic [atclp_pkg::NPAR-1:0] nmask = atclp_pkg::NPAR'((5'h1 << desc.npar) - 5'h1);

    // Form decode and check of the whole line
    wire logic eq_op   = (line_r.op == atclp_pkg::OP_EQ);
    wire logic rd_op   = (line_r.op == atclp_pkg::OP_READ);
    wire atclp_pkg::atclp_form_e form_w =
        (line_r.op == atclp_pkg::OP_NONE) ? atclp_pkg::F_EXEC :                    // RULE1
        eq_op ? (desc.eq_exec ? atclp_pkg::F_EXEC : atclp_pkg::F_SET) :           // RULE2
        (line_r.op == atclp_pkg::OP_TEST) ? atclp_pkg::F_TEST :                   // RULE4
        (desc.xread ? atclp_pkg::F_XREAD : atclp_pkg::F_READ);                    // RULE6
    wire logic form_ok =
        (line_r.op == atclp_pkg::OP_NONE) ? desc.bare_ok :
        eq_op ? (desc.npar != 3'h0) :
        rd_op ? (desc.has_read | desc.xread) : 1'b1;                               // RULE7 RULE23
    wire logic empty_ln = (line_r.name == '0) & (line_r.op == atclp_pkg::OP_NONE) & ~line_r.syn;
    wire logic extra_w  = line_r.xtra | (|(line_r.pres & ~nmask));
    wire logic miss_man = eq_op & (|(desc.mand & ~line_r.pres & nmask));          // RULE18
    wire logic undef_w  = eq_op & (|(~line_r.pres & ~desc.has_def & ~desc.mand
                                     & ~vld_r[cmd_w] & nmask));                   // RULE16 RULE17
    wire logic bad_form = ~known | ~form_ok | (extra_w & xparm_err_i);           // RULE13 RULE23
    wire logic chk_err  = line_r.syn | miss_man | bad_form | undef_w;
    wire logic [7:0] cme_w = (line_r.syn | miss_man) ? atclp_pkg::CME_SYNTAX :
                             bad_form ? atclp_pkg::CME_NOSUP : atclp_pkg::CME_RANGE;

    // Walk over the parameter positions; reads lead by one step
    wire logic [atclp_pkg::PIW-1:0] wj = atclp_pkg::PIW'(step_r - 1'b1);
    wire logic in_walk = (step_r != '0);
    wire logic [atclp_pkg::AW-1:0] rd_addr =
        atclp_pkg::AW'(cmd_w * atclp_pkg::NPAR + step_r[atclp_pkg::PIW-1:0]);
    wire logic [atclp_pkg::AW-1:0] wr_addr = atclp_pkg::AW'(cmd_w * atclp_pkg::NPAR + wj);
    wire logic [atclp_pkg::PW-1:0] rd_data;
    wire logic set_f    = (form_w == atclp_pkg::F_SET);
    // Read and test queries answer through reports only, never as an action
    wire logic act_form = (form_w != atclp_pkg::F_READ) & (form_w != atclp_pkg::F_TEST);
    wire logic w_here   = (st_r == atclp_pkg::S_WRITE) & in_walk & nmask[wj];
    wire logic w_given  = line_r.pres[wj] | desc.has_def[wj];
    wire logic wr_en    = w_here & set_f & w_given;                               // RULE3
    wire logic [atclp_pkg::PW-1:0] res_val =
        line_r.pres[wj] ? line_r.val[wj] :
        desc.has_def[wj] ? desc.dflt[wj] : rd_data;                               // RULE15 RULE16
    wire logic walk_end = (step_r == atclp_pkg::SW'(atclp_pkg::NPAR));

    atclp_pmem #(
        .W     (atclp_pkg::PW),
        .DEPTH (atclp_pkg::NCMD * atclp_pkg::NPAR),
        .AW    (atclp_pkg::AW)
    ) u_pmem (
        .clk_i     (clk_i),
        .wr_en_i   (wr_en),
        .wr_addr_i (wr_addr),
        .wr_data_i (res_val),
        .rd_addr_i (rd_addr),
        .rd_data_o (rd_data)
    );

    assign chr_ready_o = (st_r == atclp_pkg::S_IDLE) | (st_r == atclp_pkg::S_PFX)
                       | (st_r == atclp_pkg::S_NAME) | (st_r == atclp_pkg::S_OPEQ)
                       | (st_r == atclp_pkg::S_PARAM) | (st_r == atclp_pkg::S_TAIL)
                       | (st_r == atclp_pkg::S_DATA);
    assign act_o = act_r;
    assign rpt_o = rpt_r;
    assign res_o = res_r;

    // Line parser and sequencing
    always_comb begin
        st_nxt   = st_r;
        line_nxt = line_r;
        pidx_nxt = pidx_r;
        res_nxt  = '0;
        rpt_nxt  = '0;
        unique case (st_r)
            atclp_pkg::S_IDLE: begin
                if (take && up_chr == atclp_pkg::CH_A) begin
                    st_nxt = atclp_pkg::S_PFX;
                end
            end
            atclp_pkg::S_PFX: begin
                if (take) begin
                    if (up_chr == atclp_pkg::CH_T) begin // RULE19
                        line_nxt = '0;
                        pidx_nxt = '0;
                        st_nxt   = atclp_pkg::S_NAME;
                    end else if (chr_i == atclp_pkg::CH_SLASH) begin // RULE19
                        line_nxt = prev_r ? last_r : '0;
                        line_nxt.syn = ~prev_r;
                        st_nxt   = atclp_pkg::S_CHECK;
                    end else if (up_chr != atclp_pkg::CH_A) begin
                        st_nxt = atclp_pkg::S_IDLE;
                    end
                end
            end
            atclp_pkg::S_NAME: begin
                if (take) begin
                    if (is_term) begin
                        st_nxt = atclp_pkg::S_CHECK;
                    end else if (chr_i == atclp_pkg::CH_EQ) begin
                        line_nxt.op = atclp_pkg::OP_EQ;
                        st_nxt      = atclp_pkg::S_OPEQ;
                    end else if (chr_i == atclp_pkg::CH_QMARK) begin
                        line_nxt.op = atclp_pkg::OP_READ; // RULE5
                        st_nxt      = atclp_pkg::S_TAIL;
                    end else if (!is_sp) begin
                        line_nxt.name = {line_r.name[atclp_pkg::NAMEW-9:0], up_chr};
                    end
                end
            end
            atclp_pkg::S_OPEQ, atclp_pkg::S_PARAM: begin
                if (take) begin
                    st_nxt = atclp_pkg::S_PARAM;
                    if (st_r == atclp_pkg::S_OPEQ && chr_i == atclp_pkg::CH_QMARK) begin
                        line_nxt.op = atclp_pkg::OP_TEST; // RULE4
                        st_nxt      = atclp_pkg::S_TAIL;
                    end else if (is_term) begin
                        // Positions never reached stay absent: dropped tail
                        st_nxt = (known && desc.has_data) ? atclp_pkg::S_DATA
                                                          : atclp_pkg::S_CHECK; // RULE10 RULE11 RULE14
                    end else if (chr_i == atclp_pkg::CH_COMMA) begin
                        if (pidx_r == atclp_pkg::PIW'(atclp_pkg::NPAR - 1)) begin
                            line_nxt.xtra = 1'b1; // RULE13
                        end else begin
                            pidx_nxt = pidx_r + 1'b1; // RULE8 RULE9
                        end
                    end else if (is_dig) begin
                        if (!line_r.xtra) begin
                            line_nxt.pres[pidx_r] = 1'b1;
                            line_nxt.val[pidx_r]  = atclp_pkg::PW'(line_r.val[pidx_r]
                                                    * atclp_pkg::DEC_BASE + dig_val); // RULE8
                        end
                    end else if (!is_sp && !line_r.xtra) begin
                        line_nxt.syn = 1'b1;
                    end
                end
            end
            atclp_pkg::S_TAIL: begin
                if (take) begin
                    if (is_term) begin
                        st_nxt = atclp_pkg::S_CHECK;
                    end else if (!is_sp) begin
                        line_nxt.syn = 1'b1;
                    end
                end
            end
            atclp_pkg::S_DATA: begin
                // User data is not interpreted; ESC cancels silently
                if (take && chr_i == atclp_pkg::CH_CTRLZ) begin
                    st_nxt = atclp_pkg::S_CHECK; // RULE14
                end else if (take && chr_i == atclp_pkg::CH_ESC) begin
                    st_nxt = atclp_pkg::S_IDLE;
                end
            end
            atclp_pkg::S_CHECK: begin
                if (empty_ln) begin
                    st_nxt = atclp_pkg::S_FINAL;
                end else if (chk_err) begin
                    res_nxt.valid = 1'b1; // RULE17 RULE18 RULE22 RULE23
                    res_nxt.code  = cme_mode_i ? atclp_pkg::R_CME : atclp_pkg::R_ERROR;
                    res_nxt.cme   = cme_mode_i ? cme_w : '0;
                    st_nxt        = atclp_pkg::S_IDLE;
                end else if (form_w == atclp_pkg::F_READ || form_w == atclp_pkg::F_TEST) begin
                    st_nxt = atclp_pkg::S_REPORT;
                end else if (form_w == atclp_pkg::F_XREAD) begin
                    st_nxt = atclp_pkg::S_FINAL; // RULE6
                end else begin
                    st_nxt = atclp_pkg::S_WRITE;
                end
            end
            atclp_pkg::S_WRITE: begin
                if (walk_end) begin
                    st_nxt = atclp_pkg::S_FINAL;
                end
            end
            atclp_pkg::S_REPORT: begin
                if (in_walk && nmask[wj]) begin
                    rpt_nxt.valid    = 1'b1;
                    rpt_nxt.idx      = wj;
                    rpt_nxt.is_range = (form_w == atclp_pkg::F_TEST);               // RULE4
                    rpt_nxt.defined  = (form_w == atclp_pkg::F_TEST) | vld_r[cmd_w][wj];
                    rpt_nxt.val      = (form_w == atclp_pkg::F_TEST) ? desc.lo[wj] : rd_data; // RULE5
                    rpt_nxt.hi       = (form_w == atclp_pkg::F_TEST) ? desc.hi[wj] : '0;
                end
                if (walk_end) begin
                    st_nxt = atclp_pkg::S_FINAL;
                end
            end
            atclp_pkg::S_FINAL: begin
                res_nxt.valid = 1'b1; // RULE22
                res_nxt.code  = atclp_pkg::R_OK;
                st_nxt        = atclp_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r   <= atclp_pkg::S_IDLE;
            line_r <= '0;
            pidx_r <= '0;
            res_r  <= '0;
            rpt_r  <= '0;
        end else begin
            st_r   <= st_nxt;
            line_r <= line_nxt;
            pidx_r <= pidx_nxt;
            res_r  <= res_nxt;
            rpt_r  <= rpt_nxt;
        end
    end

    // Last good line kept for the repeat prefix
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            last_r <= '0;
            prev_r <= 1'b0;
        end else if (st_r == atclp_pkg::S_CHECK && !empty_ln && !chk_err) begin
            last_r <= line_r; // RULE19
            prev_r <= 1'b1;
        end
    end

    // Step counter for write and report walks
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            step_r <= '0;
        end else if ((st_r == atclp_pkg::S_WRITE || st_r == atclp_pkg::S_REPORT) && !walk_end) begin
            step_r <= step_r + 1'b1;
        end else begin
            step_r <= '0;
        end
    end

    // Validity of stored values; only a clean set line touches it
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vld_r <= '0;
        end else if (wr_en) begin
            vld_r[cmd_w][wj] <= 1'b1; // RULE3 RULE23
        end
    end

    // Resolved values handed to the action
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rval_r <= '0;
        end else if (st_r == atclp_pkg::S_CHECK) begin
            rval_r <= '0;
        end else if (w_here) begin
            rval_r[wj] <= res_val; // RULE15 RULE16
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            act_r <= '0;
        end else if (st_r == atclp_pkg::S_FINAL && !empty_ln && act_form) begin
            act_r.valid <= 1'b1; // RULE1 RULE2 RULE6
            act_r.cmd   <= cmd_w;
            act_r.form  <= form_w;
            act_r.given <= line_r.pres & nmask;
            act_r.val   <= rval_r;
        end else begin
            act_r.valid <= 1'b0;
        end
    end

endmodule // atclp_parser

`default_nettype wire

// ---- testbench/atclp_props.sv ----
`timescale 1ns/1ps
`default_nettype none

module atclp_props (
    // Clock and reset
    input wire logic                  clk_i,
    input wire logic                  nrst_i,
    // Watched ports
    input wire logic                  chr_ready_o,
    input wire logic                  cme_mode_i,
    input wire atclp_pkg::atclp_act_s act_o,
    input wire atclp_pkg::atclp_rpt_s rpt_o,
    input wire atclp_pkg::atclp_res_s res_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wire logic ok  = res_o.valid && res_o.code == atclp_pkg::R_OK;
    wire logic bad = res_o.valid && res_o.code != atclp_pkg::R_OK;

    a_res_one_cycle: assert property (res_o.valid |=> !res_o.valid) else $error("result held too long");
    a_busy_before_res: assert property (res_o.valid |-> !$past(chr_ready_o))
        else $error("link open while busy");
    a_act_needs_ok: assert property (act_o.valid |-> ok) else $error("action without success");
    a_rpt_then_ok: assert property (rpt_o.valid |-> ##[1:4] ok) else $error("report not closed by success");
    a_plain_error: assert property (res_o.valid && !cme_mode_i |->
        res_o.code != atclp_pkg::R_CME && res_o.cme == 8'h00) else $error("extended code in plain mode");
    a_ext_error: assert property (bad && cme_mode_i |-> res_o.code == atclp_pkg::R_CME)
        else $error("plain error in ext mode");
    a_range_defined: assert property (rpt_o.valid && rpt_o.is_range |-> rpt_o.defined)
        else $error("range not defined");
    a_rpt_in_order: assert property (rpt_o.valid && rpt_o.idx != 0 |->
        $past(rpt_o.valid) && rpt_o.idx == $past(rpt_o.idx) + 1) else $error("report positions out of order");
    a_act_form_legal: assert property (act_o.valid |->
        act_o.form inside {atclp_pkg::F_EXEC, atclp_pkg::F_SET, atclp_pkg::F_XREAD})
        else $error("illegal action form");

    c_set: cover property (act_o.valid && act_o.form == atclp_pkg::F_SET);
    c_test: cover property (rpt_o.valid && rpt_o.is_range);
    c_syntax: cover property (bad && res_o.cme == 8'h23);
endmodule // atclp_props

bind atclp_parser atclp_props atclp_props_inst (.clk_i, .nrst_i, .chr_ready_o, .cme_mode_i, .act_o, .rpt_o, .res_o);

`default_nettype wire

// ---- testbench/atclp_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module atclp_host (
    input  wire logic       clk_i,
    input  wire logic       chr_ready_i,
    output var  logic [7:0] chr_o,
    output var  logic       chr_valid_o
);
    initial begin
        chr_o = 8'h00;
        chr_valid_o = 1'b0;
    end

    // Lines go out whole and in order; result fields beyond the known ones are never examined
    task automatic send(input string s, output bit ok);
        int n;
        ok = 1'b1;
        for (int i = 0; i < s.len(); i++) begin
            @(posedge clk_i);
            chr_o <= s[i];
            chr_valid_o <= 1'b1;
            n = 0;
            do begin
                @(negedge clk_i);
                n++;
            end while (!chr_ready_i && n < 40);
            if (!chr_ready_i) ok = 1'b0;
        end
        @(posedge clk_i);
        chr_valid_o <= 1'b0;
        // Released line shows no stale character
        chr_o <= ~chr_o;
    endtask
endmodule // atclp_host

`default_nettype wire

// ---- testbench/atclp_parser_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module atclp_parser_tb_top;
    logic                  clk_i = 1'b0;
    logic                  nrst_i = 1'b0;
    logic [7:0]            chr_i;
    logic                  chr_valid_i;
    logic                  chr_ready_o;
    logic [7:0]            term = 8'h0d;
    logic                  xp = 1'b0;
    logic                  cme = 1'b1;
    atclp_pkg::atclp_act_s act_o;
    atclp_pkg::atclp_rpt_s rpt_o;
    atclp_pkg::atclp_res_s res_o;
    int                    err_total = 0;
    int                    checks = 0;
    int                    nres = 0;
    atclp_pkg::atclp_res_e rcode;
    logic [7:0]            rcme;
    logic [63:0]           av, rv, rh;
    logic [5:0]            ag;
    logic [3:0]            rd;
    atclp_pkg::atclp_form_e af;

    always #4 clk_i = ~clk_i;

    atclp_parser atclp_parser_inst (.clk_i(clk_i), .nrst_i(nrst_i), .chr_i(chr_i), .chr_valid_i(chr_valid_i),
        .chr_ready_o(chr_ready_o), .term_char_i(term), .xparm_err_i(xp), .cme_mode_i(cme),
        .act_o(act_o), .rpt_o(rpt_o), .res_o(res_o));
    atclp_host atclp_host_inst (.clk_i(clk_i), .chr_ready_i(chr_ready_o), .chr_o(chr_i), .chr_valid_o(chr_valid_i));

    always @(posedge clk_i) begin
        if (res_o.valid) begin
            nres <= nres + 1;
            rcode <= res_o.code;
            rcme <= res_o.cme;
        end
        if (rpt_o.valid) begin
            rv[rpt_o.idx*16 +: 16] <= rpt_o.val;
            rh[rpt_o.idx*16 +: 16] <= rpt_o.hi;
            rd[rpt_o.idx] <= rpt_o.defined;
        end
        if (act_o.valid) begin
            av <= act_o.val;
            ag <= {act_o.cmd, act_o.given};
            af <= act_o.form;
        end
    end

    task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic line(input string s, input atclp_pkg::atclp_res_e c, input logic [7:0] m);
        int k;
        bit ok;
        k = nres;
        atclp_host_inst.send(s, ok);
        for (int n = 0; n < 40 && nres == k; n++) @(posedge clk_i);
        cmp("answered", 64'h1, {63'h0, ok && nres != k});
        if (nres == k) summarize();
        cmp("code", c, rcode);
        cmp("cme", m, rcme);
    endtask

    task automatic t_set;
        line("AT+CMD3=2\015", atclp_pkg::R_CME, 8'h15);
        line("AT+CMD3=1,1,9,500\015", atclp_pkg::R_OK, 8'h00);
        line("AT+CMD3= , ,15\015", atclp_pkg::R_OK, 8'h00);
        cmp("set", 64'h01f4_000f_0001_0000, av);
        cmp("form", atclp_pkg::F_SET, af);
    endtask

    task automatic t_read;
        line("AT+CMD7?\015", atclp_pkg::R_CME, 8'h04);
        line("AT+CMD3?\015", atclp_pkg::R_OK, 8'h00);
        cmp("stored", 64'h01f4_000f_0001_0000, rv);
        cmp("defined", 64'hf, {60'h0, rd});
        line("AT+CMD3=?\015", atclp_pkg::R_OK, 8'h00);
        cmp("range", 64'hffff_000f_0001_0003, rh);
    endtask

    task automatic t_exec;
        line("AT+CMD7=,,10\015\nA38\032", atclp_pkg::R_OK, 8'h00);
        cmp("exec", 64'h0000_000a_0001_0003, av);
        cmp("form", atclp_pkg::F_EXEC, af);
        cmp("given", 64'h34, {58'h0, ag});
        line("AT+CMD7=1\015\nA\032", atclp_pkg::R_CME, 8'h23);
        @(posedge clk_i) cme <= 1'b0;
        line("AT+CMD7=1,,\015\nA\032", atclp_pkg::R_ERROR, 8'h00);
    endtask

    task automatic t_misc;
        line("AT+CMD2?\015", atclp_pkg::R_OK, 8'h00);
        cmp("form", atclp_pkg::F_XREAD, af);
        line("AT+CMD3\015", atclp_pkg::R_ERROR, 8'h00);
        line("at\015", atclp_pkg::R_OK, 8'h00);
        line("A/", atclp_pkg::R_OK, 8'h00);
        line("AT+CMD3=1,0,2,3,7\015", atclp_pkg::R_OK, 8'h00);
        @(posedge clk_i) xp <= 1'b1;
        line("AT+CMD3=1,0,2,3,7\015", atclp_pkg::R_ERROR, 8'h00);
        @(posedge clk_i) term <= 8'h21;
        line("AT!", atclp_pkg::R_OK, 8'h00);
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_set();
        t_read();
        t_exec();
        t_misc();
        summarize();
    end
endmodule // atclp_parser_tb_top

`default_nettype wire
